// ==== src/cac_ctrl.sv ====
// control and status register of the counter array, with its counter
//
// Overview of operation
// - the overflow flag in bit 7 sets when the array counter wraps from its maximum to zero.
// - a set overflow flag with its enable on raises the shared array interrupt request.
// - hardware never clears the overflow flag; only a software write of zero does.
// - bit 6 is the run control, zero stops the counter and one lets it count.
// - bits 5 to 0 set when the matching module reports a match or a capture.
// - a set module flag with its enable on raises the shared array interrupt request.
// - module flags stay set until software writes zero to them.
// - the register decodes at 0xD8 on page 0x00, allows single-bit access and resets to zero.
// - with the watchdog on, run writes do not stop the counter and the bit reads the software value.
// - with the watchdog on, writing one to the module 5 flag forces a watchdog reset.
`timescale 1ns/1ps
`default_nettype none
module cac_ctrl (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// special function register bus
	input  wire logic [7:0]  sfr_addr,
	input  wire logic [7:0]  sfr_page,
	input  wire logic        sfr_wr,
	input  wire logic        sfr_bit_wr,
	input  wire logic [2:0]  sfr_bit_idx,
	input  wire logic [7:0]  sfr_wdata,
	output logic      [7:0]  sfr_rdata_r,
	// module events and interrupt enables
	input  wire logic [5:0]  module_event,
	input  wire logic        ovf_int_en,
	input  wire logic [5:0]  module_int_en,
	// watchdog
	input  wire logic        watchdog_en,
	output logic             watchdog_reset_r,
	// array outputs
	output logic             array_irq_r,
	output logic             counter_running_r,
	output logic      [15:0] count_out_r
);
	logic        sel;
	logic [7:0]  wmask;
	logic [7:0]  wval;
	logic [7:0]  ctrl_r;
	logic [7:0]  ctrl_nxt;
	logic [7:0]  hw_set;
	logic        run_eff;
	logic        wrap;
	logic [15:0] count;
	logic        irq_nxt;
	logic        wd_kick;

	assign sel = (sfr_addr == cac_pkg::CTRL_ADDR) && (sfr_page == cac_pkg::CTRL_PAGE);

	// byte write touches all bits, bit write only the indexed one
	always_comb begin
		wmask = 8'h00;
		wval  = sfr_wdata;
		if (sel && sfr_wr) begin
			wmask = 8'hFF;
		end else if (sel && sfr_bit_wr) begin
			wmask = 8'h01 << sfr_bit_idx;
			wval  = {8{sfr_wdata[0]}};
		end
	end

	assign hw_set = {wrap, 1'b0, module_event};

	// one slice per register bit; the hardware set is ORed in after the write
	// so that a clear in the same cycle can never swallow an event
	for (genvar b = 0; b < $bits(ctrl_r); b++) begin : g_bit
		assign ctrl_nxt[b] = ((ctrl_r[b] & ~wmask[b]) | (wval[b] & wmask[b]))
			| hw_set[b];
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl_r <= cac_pkg::CTRL_RESET;
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// watchdog forces the counter on without touching the stored run bit
	assign run_eff = ctrl_r[cac_pkg::RUN_BIT] | watchdog_en;

	cac_counter u_counter (
		.clk     (clk),
		.sys_rst (sys_rst),
		.run     (run_eff),
		.count_r (count),
		.wrap_r  (wrap)
	);

	// the request is a level: it falls only once software clears the flag
	// or drops the enable, so a slow handler cannot miss it
	always_comb begin
		irq_nxt = (ctrl_r[cac_pkg::OVF_BIT] & ovf_int_en)
			| (|(ctrl_r[cac_pkg::NUM_MOD-1:0] & module_int_en));
	end

	// a write of one to the module 5 flag, byte or bit, is the software kick
	assign wd_kick = watchdog_en && wmask[cac_pkg::MOD5_BIT] && wval[cac_pkg::MOD5_BIT];

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			array_irq_r       <= 1'b0;
			sfr_rdata_r       <= 8'h00;
			counter_running_r <= 1'b0;
			count_out_r       <= cac_pkg::CNT_ZERO;
		end else begin
			array_irq_r       <= irq_nxt;
			sfr_rdata_r       <= ctrl_r;
			counter_running_r <= run_eff;
			count_out_r       <= count;
		end
	end

	// pulse only; the system reset it causes clears the rest
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			watchdog_reset_r <= 1'b0;
		end else begin
			watchdog_reset_r <= wd_kick;
		end
	end

	a_ovf_sets: assert property (@(posedge clk) disable iff (sys_rst)
		wrap |=> ctrl_r[cac_pkg::OVF_BIT])
		else $error("overflow flag missed a wrap");

	a_ovf_sticky: assert property (@(posedge clk) disable iff (sys_rst)
		ctrl_r[cac_pkg::OVF_BIT] && !wmask[cac_pkg::OVF_BIT] |=> ctrl_r[cac_pkg::OVF_BIT])
		else $error("overflow flag cleared by itself");

	a_mod_sticky: assert property (@(posedge clk) disable iff (sys_rst)
		ctrl_r[0] && !wmask[0] |=> ctrl_r[0])
		else $error("module 0 flag cleared by itself");

	a_mod_sets: assert property (@(posedge clk) disable iff (sys_rst)
		module_event[2] |=> ctrl_r[2])
		else $error("module 2 flag missed an event");

	// module 0 is the one the bench hits with a clear and an event together
	a_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
		module_event[0] && wmask[0] && !wval[0] |=> ctrl_r[0])
		else $error("clear beat a hardware set");

	a_irq_flag: assert property (@(posedge clk) disable iff (sys_rst)
		ctrl_r[1] && module_int_en[1] |=> array_irq_r)
		else $error("module interrupt not raised");

	a_irq_ovf: assert property (@(posedge clk) disable iff (sys_rst)
		ctrl_r[cac_pkg::OVF_BIT] && ovf_int_en |=> array_irq_r)
		else $error("overflow interrupt not raised");

	a_irq_quiet: assert property (@(posedge clk) disable iff (sys_rst)
		!(ctrl_r[cac_pkg::OVF_BIT] && ovf_int_en)
		&& !(|(ctrl_r[cac_pkg::NUM_MOD-1:0] & module_int_en))
		|=> !array_irq_r)
		else $error("interrupt raised with no enabled flag");

	a_run_stop: assert property (@(posedge clk) disable iff (sys_rst)
		!ctrl_r[cac_pkg::RUN_BIT] && !watchdog_en |=> $stable(count))
		else $error("counter moved while stopped");

	a_run_write: assert property (@(posedge clk) disable iff (sys_rst)
		sel && sfr_wr
		|=> ctrl_r[cac_pkg::RUN_BIT] == $past(sfr_wdata[cac_pkg::RUN_BIT]))
		else $error("run bit did not take the written value");

	a_run_state: assert property (@(posedge clk) disable iff (sys_rst)
		1'b1
		|=> counter_running_r == $past(ctrl_r[cac_pkg::RUN_BIT] | watchdog_en))
		else $error("run state output disagrees with run control");

	a_wd_run: assert property (@(posedge clk) disable iff (sys_rst)
		watchdog_en |=> count != $past(count))
		else $error("counter stopped under watchdog");

	a_wd_reset: assert property (@(posedge clk) disable iff (sys_rst)
		watchdog_en && sel
		&& (sfr_wr ? sfr_wdata[cac_pkg::MOD5_BIT]
			: (sfr_bit_wr && (sfr_bit_idx == 3'h5) && sfr_wdata[0]))
		|=> watchdog_reset_r)
		else $error("forced watchdog reset missing");

	a_wd_quiet: assert property (@(posedge clk) disable iff (sys_rst)
		!watchdog_en |=> !watchdog_reset_r)
		else $error("watchdog reset without the watchdog on");

	// writes elsewhere on the bus must leave the register alone
	a_other_addr: assert property (@(posedge clk) disable iff (sys_rst)
		!sel && (hw_set == 8'h00)
		|=> ctrl_r == $past(ctrl_r))
		else $error("register changed by a foreign write");

	// a bit write may only touch the indexed bit
	a_bitwr_one: assert property (@(posedge clk) disable iff (sys_rst)
		sel && sfr_bit_wr && !sfr_wr && (hw_set == 8'h00)
		|=> ((ctrl_r ^ $past(ctrl_r)) & ~$past(wmask)) == 8'h00)
		else $error("bit write touched another bit");

	for (genvar m = 0; m < cac_pkg::NUM_MOD; m++) begin : g_mod_chk
		a_flag_sets: assert property (@(posedge clk) disable iff (sys_rst)
			module_event[m] |=> ctrl_r[m])
			else $error("module flag missed an event");
	end

	c_wrap:  cover property (@(posedge clk) wrap);
	c_irq:   cover property (@(posedge clk) array_irq_r);
	c_wdrst: cover property (@(posedge clk) watchdog_reset_r);
	c_bitwr: cover property (@(posedge clk) sel && sfr_bit_wr);
	c_setwin: cover property (@(posedge clk) module_event[0] && wmask[0] && !wval[0]);
endmodule : cac_ctrl
`default_nettype wire

// ==== src/cac_pkg.sv ====
// constants for the counter array control and status register
package cac_pkg;
	localparam logic [7:0] CTRL_ADDR  = 8'hD8;
	localparam logic [7:0] CTRL_PAGE  = 8'h00;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int         OVF_BIT    = 7;
	localparam int         RUN_BIT    = 6;
	localparam int         MOD5_BIT   = 5;
	localparam int         NUM_MOD    = 6;
	localparam int         CNT_W      = 16;
	localparam logic [15:0] CNT_MAX   = 16'hFFFF;
	localparam logic [15:0] CNT_ZERO  = 16'h0000;
	localparam logic [2:0] BIT_IDX_W  = 3'h3;
endpackage : cac_pkg

// ==== src/cac_counter.sv ====
// 16-bit array counter with wrap detection
`timescale 1ns/1ps
`default_nettype none
module cac_counter (
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        sys_rst,
	// control
	input  wire logic                        run,
	// state
	output logic [cac_pkg::CNT_W-1:0]        count_r,
	output logic                             wrap_r
);
	// wrap pulse is registered so the flag sets one cycle after the count hits zero
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			count_r <= cac_pkg::CNT_ZERO;
			wrap_r  <= 1'b0;
		end else begin
			wrap_r <= run && (count_r == cac_pkg::CNT_MAX);
			if (run) begin
				count_r <= count_r + 16'h0001;
			end
		end
	end
endmodule : cac_counter
`default_nettype wire

// ==== sim/cac_core_model.sv ====
// processor core model: single-cycle register bus writes
`timescale 1ns/1ps
`default_nettype none
module cac_core_model (
	// clock
	input  wire logic       clk,
	// register bus
	output logic      [7:0] sfr_addr,
	output logic      [7:0] sfr_page,
	output logic            sfr_wr,
	output logic            sfr_bit_wr,
	output logic      [2:0] sfr_bit_idx,
	output logic      [7:0] sfr_wdata
);
	initial begin
		{sfr_addr, sfr_page, sfr_wr, sfr_bit_wr, sfr_bit_idx, sfr_wdata} = '0;
	end
	// flags are cleared only by writing zero here
	task automatic acc(input logic [7:0] a, input logic b, input logic [2:0] i,
		input logic [7:0] d);
		@(negedge clk);
		{sfr_addr, sfr_wr, sfr_bit_wr, sfr_bit_idx, sfr_wdata} = {a, !b, b, i, d};
		@(negedge clk);
		// idle bus leaves the address and data off the last value
		{sfr_addr, sfr_wr, sfr_bit_wr, sfr_wdata} = {8'h00, 2'b00, ~d};
	endtask : acc
endmodule : cac_core_model
`default_nettype wire

// ==== sim/counter_array_control_flags_tb.sv ====
// self-checking bench for the counter array control register
`timescale 1ns/1ps
`default_nettype none
module counter_array_control_flags_tb;
	logic clk = 0, sys_rst = 1, ovf_int_en = 1, watchdog_en = 0;
	logic [5:0] module_event = '0, module_int_en = '1;
	logic [7:0] a, p, wd, rd;
	logic w, bw, wdr, irq, run;
	logic [2:0] bi;
	logic [15:0] cnt, c;
	int err_count = 0, n_checks = 0, i;
	always #20 clk = ~clk;
	cac_core_model core (.clk(clk), .sfr_addr(a), .sfr_page(p), .sfr_wr(w),
		.sfr_bit_wr(bw), .sfr_bit_idx(bi), .sfr_wdata(wd));
	cac_ctrl dut (.clk(clk), .sys_rst(sys_rst), .sfr_addr(a), .sfr_page(p), .sfr_wr(w),
		.sfr_bit_wr(bw), .sfr_bit_idx(bi), .sfr_wdata(wd), .sfr_rdata_r(rd),
		.module_event(module_event), .ovf_int_en(ovf_int_en), .module_int_en(module_int_en),
		.watchdog_en(watchdog_en), .watchdog_reset_r(wdr), .array_irq_r(irq),
		.counter_running_r(run), .count_out_r(cnt));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	task automatic t_run;
		chk(rd, 16'h0000);
		core.acc(8'hD8, 0, 3'h0, 8'h40);
		tick(1);
		chk(rd, 16'h0040);
		chk(run, 1'b1);
		c = cnt;
		tick(5);
		chk(cnt, c + 16'h0005);
	endtask : t_run
	task automatic t_events;
		for (i = 0; i < 6; i++) begin
			module_event[i] = 1'b1;
			tick(1);
			module_event[i] = 1'b0;
			tick(1);
			chk(rd[i], 1'b1);
			chk(irq, 1'b1);
			tick(4);
			chk(rd[i], 1'b1);
			core.acc(8'hD8, 1, i[2:0], 8'h00);
			tick(1);
			chk({rd, irq}, 9'h080);
		end
		// a clear in the same edge as an event must not lose the event
		fork
			core.acc(8'hD8, 0, 3'h0, 8'h40);
			begin
				tick(1);
				module_event[0] = 1'b1;
				tick(1);
				module_event[0] = 1'b0;
			end
		join
		tick(1);
		chk(rd, 16'h0041);
		core.acc(8'hD9, 0, 3'h0, 8'hFF);
		tick(1);
		chk(rd, 16'h0041);
	endtask : t_events
	task automatic t_overflow;
		module_int_en = '0;
		tick(2);
		chk(irq, 1'b0);
		for (i = 0; cnt !== 16'hFFFF && i < 70000; i++) tick(1);
		tick(3);
		chk(rd[7], 1'b1);
		chk(irq, 1'b1);
		tick(10);
		chk(rd[7], 1'b1);
		ovf_int_en = 1'b0;
		tick(2);
		chk(irq, 1'b0);
		ovf_int_en = 1'b1;
		module_int_en = '1;
	endtask : t_overflow
	task automatic t_watchdog;
		watchdog_en = 1'b1;
		core.acc(8'hD8, 0, 3'h0, 8'h00);
		tick(1);
		chk({rd[6], run}, 2'b01);
		core.acc(8'hD8, 1, 3'h5, 8'h01);
		i = 0;
		repeat (3) begin
			if (wdr === 1'b1) i++;
			tick(1);
		end
		chk(i[15:0], 16'h0001);
	endtask : t_watchdog
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		tick(16);
		sys_rst = 1'b0;
		t_run();
		t_events();
		t_overflow();
		t_watchdog();
		tally_and_finish();
	end
	// overflow alone needs some 65600 cycles, so 80000 leaves margin
	initial begin
		repeat (80000) @(posedge clk);
		err_count++;
		tally_and_finish();
	end
endmodule : counter_array_control_flags_tb
`default_nettype wire
